// *** hdl/mmsd_pkg.sv ***
// constants and types of the memory space decoder
//
// Summary of operation
// - program, data and stack accesses use three separate address spaces, each decoded on its own.
// - program space is addressed by a 12-bit program counter covering 4096 locations.
// - user program memory spans program addresses 0080h to 0F9Fh, 3872 bytes.
// - interrupt vectors sit at 0FF0h to 0FF7h and 0FF8h to 0FFBh is reserved.
// - the non-maskable vector sits at 0FFCh to 0FFDh and the reset vector at 0FFEh to 0FFFh.
// - the stack holds six return-address levels for calls and interrupts.
// - program memory constants are readable through a 64-byte window in data space in run mode only; in programming mode window reads get no answer.
// - data space holds 60 bytes of general RAM beside the core, port and peripheral registers.
// - extra RAM and EEPROM pages appear as 64-byte banks at data addresses 00h to 3Fh.
// - with readout protection selected, external reads of program memory are refused.
// - programming mode is entered when the test pin is at programming level at the first clock after reset is released.
// - the read-only window occupies data addresses 0040h to 007Fh.
// - a window read address is the window position register above the low six data address bits.
// - reset leaves the window position register unchanged.
package mmsd_pkg;
   localparam int PA_W = 12;
   localparam int DA_W = 8;
   localparam logic [11:0] PA_USER_LO = 12'h080;
   localparam logic [11:0] PA_USER_HI = 12'hf9f;
   localparam logic [11:0] PA_VEC_LO = 12'hff0;
   localparam logic [11:0] PA_VEC_HI = 12'hff7;
   localparam logic [11:0] PA_RSV_LO = 12'hff8;
   localparam logic [11:0] PA_RSV_HI = 12'hffb;
   localparam logic [11:0] PA_NMI_LO = 12'hffc;
   localparam logic [11:0] PA_NMI_HI = 12'hffd;
   localparam logic [11:0] PA_RST_LO = 12'hffe;
   localparam logic [7:0] FILL_BYTE = 8'hff;
   localparam logic [7:0] DA_BANK_LO = 8'h00;
   localparam logic [7:0] DA_BANK_HI = 8'h3f;
   localparam logic [7:0] DA_WIN_LO = 8'h40;
   localparam logic [7:0] DA_WIN_HI = 8'h7f;
   localparam logic [7:0] DA_RAM_LO = 8'h84;
   localparam logic [7:0] DA_RAM_HI = 8'hbf;
   localparam logic [7:0] DA_WINPOS = 8'hc9;
   localparam logic [7:0] DA_BANKSEL = 8'he8;
   localparam int WIN_LSB_W = 6;
   localparam int WINPOS_W = 6;
   localparam int BANK_W = 2;
   localparam int RAM_WORDS = 60;
   localparam int STACK_DEPTH = 6;
   localparam logic [2:0] STACK_DEPTH_C = 3'h6;
   typedef enum logic [2:0] {mmsd_pr_rsv, mmsd_pr_user, mmsd_pr_vec, mmsd_pr_vrsv, mmsd_pr_nmi,
      mmsd_pr_reset} mmsd_pregion_e;
   typedef enum logic [2:0] {mmsd_dr_bank, mmsd_dr_window, mmsd_dr_ram, mmsd_dr_periph} mmsd_dregion_e;
   typedef enum {mmsd_st_run, mmsd_st_prog} mmsd_mode_e;
endpackage

// *** hdl/mmsd_stack.sv ***
// six-level return address stack
`timescale 1ns/1ps
`default_nettype none
module mmsd_stack
   import mmsd_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // push and pop
   input wire logic push,
   input wire logic pop,
   input wire logic [mmsd_pkg::PA_W-1:0] push_addr,
   output logic [mmsd_pkg::PA_W-1:0] top_addr,
   output logic [2:0] level,
   output logic overflow
);
   logic [PA_W-1:0] mem [STACK_DEPTH];
   logic [PA_W-1:0] next_mem [STACK_DEPTH];
   logic [2:0] next_level;
   logic next_overflow;
   // ==========================================
   // next state
   // six level stack
   always_comb
   begin
      next_mem = mem;
      next_level = level;
      next_overflow = overflow;
      if (push && !pop)
      begin
         for (int i = STACK_DEPTH - 1; i > 0; i--)
            next_mem[i] = mem[i-1];
         next_mem[0] = push_addr;
         if (level == STACK_DEPTH_C)
            next_overflow = 1'b1;
         else
            next_level = level + 3'h1;
      end
      else if (pop && !push)
      begin
         for (int i = 0; i < STACK_DEPTH - 1; i++)
            next_mem[i] = mem[i+1];
         if (level != 3'h0)
            next_level = level - 3'h1;
      end
   end
   // ==========================================
   // registers
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         level <= 3'h0;
         overflow <= 1'b0;
         for (int i = 0; i < STACK_DEPTH; i++)
            mem[i] <= 12'h000;
      end
      else
      begin
         level <= next_level;
         overflow <= next_overflow;
         mem <= next_mem;
      end
   end
   assign top_addr = mem[0];
endmodule
`default_nettype wire

// *** hdl/mmsd_pdec.sv ***
// program address region decoder
`timescale 1ns/1ps
`default_nettype none
module mmsd_pdec
   import mmsd_pkg::*;
(
   // address and region
   input wire logic [mmsd_pkg::PA_W-1:0] addr,
   output mmsd_pkg::mmsd_pregion_e region
);
   // ==========================================
   // region decode
   always_comb
   begin
      if (addr >= PA_USER_LO && addr <= PA_USER_HI)
         region = mmsd_pr_user;
      else if (addr >= PA_VEC_LO && addr <= PA_VEC_HI)
         region = mmsd_pr_vec;
      else if (addr >= PA_RSV_LO && addr <= PA_RSV_HI)
         region = mmsd_pr_vrsv;
      else if (addr >= PA_NMI_LO && addr <= PA_NMI_HI)
         region = mmsd_pr_nmi;
      else if (addr >= PA_RST_LO)
         region = mmsd_pr_reset;
      else
         region = mmsd_pr_rsv;
   end
endmodule
`default_nettype wire

// *** hdl/mmsd_top.sv ***
// memory space decoder top level
`timescale 1ns/1ps
`default_nettype none
module mmsd_top
   import mmsd_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // strap and options
   input wire logic test_pin_high,
   input wire logic readout_protect,
   output logic prog_mode,
   // program fetch
   input wire logic fetch_req,
   input wire logic [mmsd_pkg::PA_W-1:0] program_counter,
   output logic [mmsd_pkg::PA_W-1:0] pmem_addr,
   output logic pmem_en,
   output mmsd_pkg::mmsd_pregion_e fetch_region,
   // data access
   input wire logic data_req,
   input wire logic data_we,
   input wire logic [mmsd_pkg::DA_W-1:0] data_addr,
   input wire logic [7:0] data_wdata,
   input wire logic [7:0] pmem_rdata,
   input wire logic [7:0] bank_rdata,
   input wire logic [7:0] periph_rdata,
   output logic [7:0] data_rdata,
   output logic data_valid,
   output logic bank_en,
   output logic bank_we,
   output logic [mmsd_pkg::BANK_W-1:0] bank_sel,
   output logic [5:0] bank_addr,
   output logic [7:0] bank_wdata,
   output logic periph_en,
   output logic periph_we,
   output logic [mmsd_pkg::DA_W-1:0] periph_addr,
   output logic [7:0] periph_wdata,
   // external readout
   input wire logic ext_read_req,
   input wire logic [mmsd_pkg::PA_W-1:0] ext_read_addr,
   output logic [7:0] ext_read_data,
   output logic ext_read_valid,
   output logic ext_read_refused,
   // stack
   input wire logic stack_push,
   input wire logic stack_pop,
   input wire logic [mmsd_pkg::PA_W-1:0] stack_push_addr,
   output logic [mmsd_pkg::PA_W-1:0] stack_top,
   output logic [2:0] stack_level,
   output logic stack_overflow
);
   mmsd_mode_e mode, next_mode;
   logic strap_seen, next_strap_seen;
   logic [WINPOS_W-1:0] window_position_register, next_window_position_register;
   logic [BANK_W-1:0] next_bank_sel;
   logic [7:0] ram [RAM_WORDS];
   logic [7:0] next_ram [RAM_WORDS];
   logic [7:0] next_data_rdata;
   logic next_data_valid;
   logic [7:0] next_ext_read_data;
   logic next_ext_read_valid, next_ext_read_refused;
   logic rd_window, rd_ram, rd_bank, rd_periph;
   logic next_rd_window, next_rd_ram, next_rd_bank, next_rd_periph;
   logic [7:0] ram_q, next_ram_q;
   mmsd_dregion_e dregion;
   logic rom_window_select;
   logic [5:0] ram_idx;
   logic ext_go;

   // ==========================================
   // program space
   // twelve bit fetch
   mmsd_pdec mmsd_pdec_i
   (
      .addr(program_counter),
      .region(fetch_region)
   );

   // ==========================================
   // stack space
   // stack decoded apart
   mmsd_stack mmsd_stack_i
   (
      .clk(clk),
      .reset_n(reset_n),
      .push(stack_push),
      .pop(stack_pop),
      .push_addr(stack_push_addr),
      .top_addr(stack_top),
      .level(stack_level),
      .overflow(stack_overflow)
   );

   // ==========================================
   // data space decode
   always_comb
   begin
      if (data_addr <= DA_BANK_HI)
         dregion = mmsd_dr_bank;
      else if (data_addr >= DA_WIN_LO && data_addr <= DA_WIN_HI)
         dregion = mmsd_dr_window;
      else if (data_addr >= DA_RAM_LO && data_addr <= DA_RAM_HI)
         dregion = mmsd_dr_ram;
      else
         dregion = mmsd_dr_periph;
   end
   assign rom_window_select = data_req && !data_we && (dregion == mmsd_dr_window) && (mode == mmsd_st_run);
   assign ram_idx = 6'(data_addr - DA_RAM_LO);
   assign ext_go = ext_read_req && (mode == mmsd_st_prog);

   // ==========================================
   // program memory port arbitration
   always_comb
   begin
      pmem_en = 1'b0;
      pmem_addr = program_counter;
      if (rom_window_select)
      begin
         pmem_en = 1'b1;
         pmem_addr = {window_position_register, data_addr[WIN_LSB_W-1:0]};
      end
      else if (ext_go && !readout_protect)
      begin
         pmem_en = 1'b1;
         pmem_addr = ext_read_addr;
      end
      else if (fetch_req)
         pmem_en = 1'b1;
   end

   // ==========================================
   // bank and peripheral strobes
   always_comb
   begin
      bank_en = data_req && (dregion == mmsd_dr_bank);
      bank_we = bank_en && data_we;
      bank_addr = data_addr[5:0];
      bank_wdata = data_wdata;
      periph_en = data_req && (dregion == mmsd_dr_periph) && (data_addr != DA_WINPOS) && (data_addr != DA_BANKSEL);
      periph_we = periph_en && data_we;
      periph_addr = data_addr;
      periph_wdata = data_wdata;
   end

   // ==========================================
   // state next values
   always_comb
   begin
      next_mode = mode;
      next_strap_seen = strap_seen;
      next_window_position_register = window_position_register;
      next_bank_sel = bank_sel;
      next_ram = ram;
      next_ram_q = ram_q;
      if (!strap_seen)
      begin
         next_strap_seen = 1'b1;
         next_mode = test_pin_high ? mmsd_st_prog : mmsd_st_run;
      end
      if (data_req && data_we && data_addr == DA_WINPOS)
         next_window_position_register = data_wdata[WINPOS_W-1:0];
      if (data_req && data_we && data_addr == DA_BANKSEL)
         next_bank_sel = data_wdata[BANK_W-1:0];
      if (data_req && dregion == mmsd_dr_ram)
      begin
         if (data_we)
            next_ram[ram_idx] = data_wdata;
         next_ram_q = ram[ram_idx];
      end
   end

   // ==========================================
   // answer next values
   always_comb
   begin
      next_rd_window = rom_window_select;
      next_rd_ram = data_req && !data_we && dregion == mmsd_dr_ram;
      next_rd_bank = data_req && !data_we && dregion == mmsd_dr_bank;
      next_rd_periph = data_req && !data_we && dregion == mmsd_dr_periph;
      next_data_valid = rd_window || rd_ram || rd_bank || rd_periph;
      if (rd_window)
         next_data_rdata = pmem_rdata;
      else if (rd_ram)
         next_data_rdata = ram_q;
      else if (rd_bank)
         next_data_rdata = bank_rdata;
      else if (rd_periph)
         next_data_rdata = periph_rdata;
      else
         next_data_rdata = data_rdata;
      next_ext_read_refused = ext_go && readout_protect;
      next_ext_read_valid = ext_go && !readout_protect && !rom_window_select;
      next_ext_read_data = next_ext_read_valid ? pmem_rdata : 8'h00;
   end

   // ==========================================
   // registers
   always_ff @(posedge clk)
   begin
      window_position_register <= next_window_position_register;
      ram <= next_ram;
      ram_q <= next_ram_q;
      if (!reset_n)
      begin
         mode <= mmsd_st_run;
         strap_seen <= 1'b0;
         bank_sel <= 2'h0;
         data_rdata <= 8'h00;
         data_valid <= 1'b0;
         rd_window <= 1'b0;
         rd_ram <= 1'b0;
         rd_bank <= 1'b0;
         rd_periph <= 1'b0;
         ext_read_data <= 8'h00;
         ext_read_valid <= 1'b0;
         ext_read_refused <= 1'b0;
      end
      else
      begin
         mode <= next_mode;
         strap_seen <= next_strap_seen;
         bank_sel <= next_bank_sel;
         data_rdata <= next_data_rdata;
         data_valid <= next_data_valid;
         rd_window <= next_rd_window;
         rd_ram <= next_rd_ram;
         rd_bank <= next_rd_bank;
         rd_periph <= next_rd_periph;
         ext_read_data <= next_ext_read_data;
         ext_read_valid <= next_ext_read_valid;
         ext_read_refused <= next_ext_read_refused;
      end
   end
   assign prog_mode = (mode == mmsd_st_prog);
endmodule
`default_nettype wire

// *** sim/mmsd_top_sva.sv ***
// checker of the decoder top ports
`timescale 1ns/1ps
`default_nettype none
module mmsd_top_sva
   import mmsd_pkg::*;
(
   // watched ports
   input wire logic clk, reset_n, data_req, data_we, prog_mode, pmem_en, data_valid, bank_en,
   input wire logic test_pin_high, ext_read_req, readout_protect, ext_read_refused,
   input wire logic [7:0] data_addr, data_wdata, pmem_rdata, data_rdata,
   input wire logic [11:0] pmem_addr, program_counter,
   input wire logic [5:0] bank_addr,
   input wire logic [1:0] bank_sel,
   input wire mmsd_pkg::mmsd_pregion_e fetch_region
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence win_rd;
      data_req && !data_we && data_addr[7:6] == 2'b01 && !prog_mode;
   endsequence
   sequence sel_wr;
      data_req && data_we && data_addr == 8'he8;
   endsequence
   // ====
   // properties
   a_window_addr:
   assert property (win_rd |-> pmem_en && pmem_addr[5:0] == data_addr[5:0]) else $error("window address");
   a_window_answer:
   assert property (win_rd ##1 1'b1 |=> data_valid && data_rdata == $past(pmem_rdata)) else $error("window data");
   a_bank_strobe:
   assert property (data_req && data_addr < 8'h40 |-> bank_en && bank_addr == data_addr[5:0]) else $error("bank");
   a_bank_select:
   assert property (sel_wr |=> bank_sel == $past(data_wdata[1:0])) else $error("bank select");
   a_user_region:
   assert property ((program_counter inside {[12'h080:12'hf9f]}) == (fetch_region == mmsd_pr_user))
      else $error("user region");
   a_vector_region:
   assert property (program_counter[11:3] == 9'h1fe |-> fetch_region == mmsd_pr_vec) else $error("vectors");
   a_top_vectors:
   assert property (program_counter[11:2] == 10'h3ff |-> fetch_region == (program_counter[1] ? mmsd_pr_reset :
      mmsd_pr_nmi)) else $error("nmi or reset vector");
   a_prog_strap:
   assert property (!$past(reset_n) && reset_n |=> prog_mode == $past(test_pin_high)) else $error("strap");
   a_readout_refuse:
   assert property (ext_read_req && prog_mode && readout_protect && !data_req |=> ext_read_refused)
      else $error("readout");
endmodule
bind mmsd_top mmsd_top_sva mmsd_top_sva_i (.*);
`default_nettype wire

// *** sim/mmsd_mem_model.sv ***
// program, bank and peripheral memories facing the decoder
`timescale 1ns/1ps
`default_nettype none
module mmsd_mem_model
   import mmsd_pkg::*;
(
   // requests
   input wire logic clk, pmem_en, bank_en, bank_we, periph_en,
   input wire logic [11:0] pmem_addr,
   input wire logic [1:0] bank_sel,
   input wire logic [5:0] bank_addr,
   input wire logic [7:0] bank_wdata, periph_addr,
   // answers
   output logic [7:0] pmem_rdata, bank_rdata, periph_rdata
);
   logic le;
   logic [11:0] la;
   logic [7:0] bm [256];
   function automatic logic [7:0] rom(input logic [11:0] a);
      return (a < 12'h080 || (a > 12'hf9f && a < 12'hff0) || a[11:2] == 10'h3fe) ? 8'hff : a[7:0] ^ {2{a[11:8]}};
   endfunction
   // ====
   // answer in the next cycle, inverted once released
   always @(posedge clk)
   begin
      le <= pmem_en;
      la <= pmem_addr;
      if (bank_en && bank_we) bm[{bank_sel, bank_addr}] <= bank_wdata;
      bank_rdata <= bank_en ? bm[{bank_sel, bank_addr}] : ~bank_rdata;
      periph_rdata <= periph_en ? ~periph_addr : ~periph_rdata;
   end
   assign pmem_rdata = le ? rom(la) : pmem_en ? rom(pmem_addr) : ~rom(la);
endmodule
`default_nettype wire

// *** sim/mmsd_top_test.sv ***
// self-checking bench of the memory space decoder
`timescale 1ns/1ps
`default_nettype none
module mmsd_top_test;
   import mmsd_pkg::*;
   logic clk = 0, reset_n = 0, test_pin_high = 0, readout_protect = 0, fetch_req = 0;
   logic data_req = 0, data_we = 0, ext_read_req = 0, stack_push = 0, stack_pop = 0;
   logic prog_mode, pmem_en, data_valid, bank_en, bank_we, periph_en, periph_we;
   logic ext_read_valid, ext_read_refused, stack_overflow;
   logic [11:0] program_counter = 0, ext_read_addr = 0, stack_push_addr = 0, pmem_addr, stack_top;
   logic [7:0] data_addr = 0, data_wdata = 0, pmem_rdata, bank_rdata, periph_rdata, data_rdata;
   logic [7:0] bank_wdata, periph_addr, periph_wdata, ext_read_data, d;
   logic [5:0] bank_addr, w;
   logic [1:0] bank_sel;
   logic [2:0] stack_level;
   mmsd_pregion_e fetch_region;
   int failures = 0, cmp_count = 0, seed = 32'h936a, i;
   mmsd_top mmsd_top_i (.*);
   mmsd_mem_model mmsd_mem_model_i (.*);
   always #2.5 clk = ~clk;
   // ====
   // helpers
   function automatic logic [7:0] rom(input logic [11:0] a);
      return (a < 12'h080 || (a > 12'hf9f && a < 12'hff0) || a[11:2] == 10'h3fe) ? 8'hff : a[7:0] ^ {2{a[11:8]}};
   endfunction
   function automatic mmsd_pregion_e reg_of(input logic [11:0] a);
      if (a >= 12'h080 && a <= 12'hf9f) return mmsd_pr_user;
      if (a >= 12'hff0 && a <= 12'hff7) return mmsd_pr_vec;
      if (a >= 12'hff8 && a <= 12'hffb) return mmsd_pr_vrsv;
      if (a >= 12'hffc) return a[1] ? mmsd_pr_reset : mmsd_pr_nmi;
      return mmsd_pr_rsv;
   endfunction
   function automatic logic periph_of(input logic [7:0] a);
      return (a inside {[8'h80:8'h83], [8'hc0:8'hff]}) && a != 8'hc9 && a != 8'he8;
   endfunction
   task chk(input logic [11:0] s, e);
      cmp_count++;
      if (s !== e)
      begin
         failures++;
         $display("wrong value at %0t: got %h want %h", $time, s, e);
      end
   endtask
   task stop_test;
      if (failures == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task rst(input logic t, input int n);
      reset_n = 0;
      test_pin_high = t;
      cyc(n);
      reset_n = 1;
      cyc(2);
      chk(prog_mode, t);
   endtask
   task acc(input logic we, input logic [7:0] a, wd, input logic ev, input logic [7:0] ed);
      data_req = 1;
      data_we = we;
      data_addr = a;
      data_wdata = wd;
      #1;
      chk(bank_we, we && a <= 8'h3f);
      chk(bank_wdata, wd);
      chk(periph_en, periph_of(a));
      chk(periph_we, we && periph_of(a));
      chk(periph_addr, a);
      chk(periph_wdata, wd);
      cyc(1);
      data_req = 0;
      cyc(1);
      chk(data_valid, ev);
      if (ev) chk(data_rdata, ed);
   endtask
   task ext(input logic [11:0] a, input logic p);
      cyc(1);
      readout_protect = p;
      ext_read_req = 1;
      ext_read_addr = a;
      cyc(1);
      ext_read_req = 0;
      chk(ext_read_refused, p);
      chk(ext_read_valid, !p);
      if (!p) chk(ext_read_data, rom(a));
   endtask
   // ====
   // main sequence
   initial
   begin
      rst(0, 12);
      fetch_req = 1;
      for (i = 0; i < 4096; i++)
      begin
         program_counter = 12'(i);
         #1;
         chk(pmem_addr, program_counter);
         chk(pmem_en, 1);
         chk(fetch_region, reg_of(program_counter));
         cyc(1);
      end
      fetch_req = 0;
      w = 6'($random(seed));
      acc(1, 8'hc9, {2'b00, w}, 0, 0);
      acc(0, 8'h7f, 0, 1, rom({w, 6'h3f}));
      acc(1, 8'h45, 8'h00, 0, 0);
      acc(0, 8'h45, 0, 1, rom({w, 6'h05}));
      for (i = 0; i < 8; i++)
      begin
         d = 8'($random(seed));
         acc(0, {2'b01, d[5:0]}, 0, 1, rom({w, d[5:0]}));
      end
      for (i = 0; i < 60; i++) acc(1, 8'(8'h84 + i), 8'(i * 7), 0, 0);
      for (i = 0; i < 60; i++) acc(0, 8'(8'h84 + i), 0, 1, 8'(i * 7));
      for (i = 0; i < 8; i++)
      begin
         acc(1, 8'he8, 8'(i % 4), 0, 0);
         chk(bank_sel, 12'(i % 4));
         acc(i < 4, 8'h3f, 8'(i % 4 + 8'ha0), i >= 4, 8'(i % 4 + 8'ha0));
      end
      acc(1, 8'hd2, 8'h5a, 0, 0);
      acc(0, 8'hd0, 0, 1, ~8'hd0);
      stack_push = 1;
      for (i = 0; i < 7; i++)
      begin
         stack_push_addr = 12'(i + 1);
         cyc(1);
         chk(stack_level, 12'(i < 6 ? i + 1 : 6));
         chk(stack_top, 12'(i + 1));
      end
      stack_push = 0;
      chk(stack_overflow, 1);
      stack_pop = 1;
      for (i = 0; i < 5; i++)
      begin
         chk(stack_top, 12'(7 - i));
         cyc(1);
         chk(stack_level, 12'(5 - i));
      end
      stack_pop = 0;
      rst(1, 2);
      ext(12'($random(seed)), 0);
      ext(12'($random(seed)), 1);
      acc(0, 8'h50, 0, 0, 0);
      rst(0, 2);
      acc(0, 8'h40, 0, 1, rom({w, 6'h00}));
      stop_test();
   end
   initial
   begin
      #60000;
      failures++;
      stop_test();
   end
endmodule
`default_nettype wire
